// *** rtl/qpo_map.svh ***
`ifndef QPO_MAP_SVH
`define QPO_MAP_SVH

`define QPO_IPF_DEFAULT      8
`define QPO_EDGES_PER_PULSE  4
`define QPO_PERIOD_W         24
`define QPO_STEP_W           8
`define QPO_ZERO_HOLD_NS     1000
`define QPO_CLK_PERIOD_NS    25
`define QPO_FLOW_WINDOW_NS   1000000
`define QPO_COUNT_W          32
`define QPO_VOL_W            32
`define QPO_IDLE_LEVEL       1'b0

`endif

// *** rtl/qpo_pkg.sv ***
package qpo_pkg;

  // Quadrature position, one-hot; forward walk is 00 -> 10 -> 11 -> 01 on {a,b}
  typedef enum logic [3:0] {
    PH_00 = 4'b0001,
    PH_10 = 4'b0010,
    PH_11 = 4'b0100,
    PH_01 = 4'b1000
  } phase_type;

  // Edge evaluation chosen on the counting side
  typedef enum logic [1:0] {
    EVAL_QUAD   = 2'b01,
    EVAL_DOUBLE = 2'b10
  } eval_mode_type;

endpackage

// *** rtl/quad_count_eval.sv ***
`timescale 1ns/1ps
`include "qpo_map.svh"
module quad_count_eval
  import qpo_pkg::*;
#(
  parameter int unsigned COUNT_W       = `QPO_COUNT_W,
  parameter int unsigned VOL_W         = `QPO_VOL_W,
  parameter int unsigned FLOW_WIN_CYC  = `QPO_FLOW_WINDOW_NS / `QPO_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  // Link from the device
  quad_link_if.eval            link,
  // Configuration
  input  eval_mode_type        i_eval_mode,
  input  wire logic [VOL_W-1:0] i_volume_per_count,
  input  wire logic            i_clr_overrun,
  // Results
  output logic [COUNT_W-1:0]   o_position,
  output logic [VOL_W-1:0]     o_volume,
  output logic [VOL_W-1:0]     o_flow,
  output logic [COUNT_W-1:0]   o_zero_seen,
  output logic                 o_dir_rev,
  output logic                 o_overrun
);

  localparam logic [31:0] WIN_LAST = FLOW_WIN_CYC - 1;

  typedef struct packed {
    logic [1:0]         a_sync;
    logic [1:0]         b_sync;
    logic [2:0]         z_sync;
    logic               a_prev;
    logic               b_prev;
    logic [COUNT_W-1:0] pos;
    logic [VOL_W-1:0]   vol;
    logic [VOL_W-1:0]   win_vol;
    logic [VOL_W-1:0]   flow;
    logic [31:0]        win_cnt;
    logic [COUNT_W-1:0] zeros;
    logic               dir_rev;
    logic               overrun;
  } eval_state_type;

  eval_state_type cur_ff;
  eval_state_type nxt_ff;

  logic a_now;
  logic b_now;
  logic a_chg;
  logic b_chg;
  logic take;
  logic up;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.a_sync = {cur_ff.a_sync[0], link.chan_a};
    nxt_ff.b_sync = {cur_ff.b_sync[0], link.chan_b};
    nxt_ff.z_sync = {cur_ff.z_sync[1], cur_ff.z_sync[0], link.zero_pulse};
    a_now  = cur_ff.a_sync[1];
    b_now  = cur_ff.b_sync[1];
    a_chg  = a_now ^ cur_ff.a_prev;
    b_chg  = b_now ^ cur_ff.b_prev;
    up     = a_now ^ cur_ff.b_prev;
    nxt_ff.a_prev = a_now;
    nxt_ff.b_prev = b_now;

    if (i_eval_mode == EVAL_DOUBLE) begin
      take = a_chg && !b_chg;
    end else begin
      take = a_chg ^ b_chg;
    end

    if (take) begin
      nxt_ff.dir_rev = !up;
      if (up) begin
        nxt_ff.pos     = cur_ff.pos + 1'b1;
        nxt_ff.vol     = cur_ff.vol + i_volume_per_count;
        nxt_ff.win_vol = cur_ff.win_vol + i_volume_per_count;
      end else begin
        nxt_ff.pos     = cur_ff.pos - 1'b1;
        nxt_ff.vol     = cur_ff.vol - i_volume_per_count;
        nxt_ff.win_vol = cur_ff.win_vol - i_volume_per_count;
      end
    end

    // Both channels moving in one sample means edges came too fast; set wins
    if (a_chg && b_chg) begin
      nxt_ff.overrun = 1'b1;
    end else if (i_clr_overrun) begin
      nxt_ff.overrun = 1'b0;
    end

    if (cur_ff.z_sync[1] && !cur_ff.z_sync[2]) begin
      nxt_ff.zeros = cur_ff.zeros + 1'b1;
    end

    // Flow: signed volume per fixed window
    if (cur_ff.win_cnt >= WIN_LAST) begin
      nxt_ff.win_cnt = 32'h0000_0000;
      nxt_ff.flow    = nxt_ff.win_vol;
      nxt_ff.win_vol = '0;
    end else begin
      nxt_ff.win_cnt = cur_ff.win_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign o_position  = cur_ff.pos;
  assign o_volume    = cur_ff.vol;
  assign o_flow      = cur_ff.flow;
  assign o_zero_seen = cur_ff.zeros;
  assign o_dir_rev   = cur_ff.dir_rev;
  assign o_overrun   = cur_ff.overrun;

endmodule

// *** rtl/quad_link_if.sv ***
`timescale 1ns/1ps
interface quad_link_if;
  logic chan_a;
  logic chan_b;
  logic zero_pulse;

  modport dev  (output chan_a, output chan_b, output zero_pulse);
  modport eval (input  chan_a, input  chan_b, input  zero_pulse);
endinterface

// *** rtl/quad_pulse_dev.sv ***
`timescale 1ns/1ps
`include "qpo_map.svh"
module quad_pulse_dev
  import qpo_pkg::*;
#(
  parameter int unsigned INTERP_FACTOR = `QPO_IPF_DEFAULT,
  parameter int unsigned PERIOD_W      = `QPO_PERIOD_W,
  parameter int unsigned ZERO_HOLD_NS  = `QPO_ZERO_HOLD_NS
) (
  // Clock and reset
  input  wire logic  i_mclk,
  input  wire logic  i_rst_n,
  // Sensor pins, asynchronous
  input  wire logic  i_sensor_tick,
  input  wire logic  i_sensor_rev,
  // Link to the evaluation end
  quad_link_if.dev   link,
  // Status
  output logic [5:0]          o_interp_factor,
  output logic [PERIOD_W-1:0] o_period_cycles,
  output logic                o_running
);

  // Only legal factors pass; anything else degrades to plain output
  function automatic int unsigned legal_factor(input int unsigned f);
    int unsigned r;
    r = 1;
    case (f)
      1, 2, 3, 4, 5, 8, 10, 12, 16, 24, 32: r = f;
      default: r = 1;
    endcase
    return r;
  endfunction

  // One quadrature step in the given direction
  function automatic phase_type step_phase(input phase_type p, input logic rev);
    phase_type r;
    r = PH_00;
    case (p)
      PH_00:   r = rev ? PH_01 : PH_10;
      PH_10:   r = rev ? PH_00 : PH_11;
      PH_11:   r = rev ? PH_10 : PH_01;
      PH_01:   r = rev ? PH_11 : PH_00;
      default: r = PH_00;
    endcase
    return r;
  endfunction

  localparam int unsigned FACTOR    = legal_factor(INTERP_FACTOR);
  localparam int unsigned STEPS     = FACTOR * `QPO_EDGES_PER_PULSE;
  localparam int unsigned ZERO_CYC0 = ZERO_HOLD_NS / `QPO_CLK_PERIOD_NS;
  localparam int unsigned ZERO_CYC  = (ZERO_CYC0 < 1) ? 1 : ZERO_CYC0;

  localparam logic [`QPO_STEP_W-1:0] STEPS_W  = STEPS[`QPO_STEP_W-1:0];
  localparam logic [PERIOD_W:0]      STEPS_P  = STEPS[PERIOD_W:0];
  localparam logic [7:0]             ZERO_LEN = ZERO_CYC[7:0];
  localparam logic [PERIOD_W-1:0]    PER_MAX  = {PERIOD_W{1'b1}};

  typedef struct packed {
    logic [2:0]             tick_sync;
    logic [1:0]             rev_sync;
    logic [PERIOD_W-1:0]    per_cnt;
    logic [PERIOD_W-1:0]    per_last;
    logic [PERIOD_W-1:0]    acc;
    logic [`QPO_STEP_W-1:0] steps;
    logic                   valid;
    phase_type              phase;
    logic [7:0]             zero_cnt;
    logic                   a;
    logic                   b;
    logic                   z;
  } dev_state_type;

  dev_state_type cur_ff;
  dev_state_type nxt_ff;

  logic              tick_edge;
  logic [PERIOD_W:0] acc_sum;
  phase_type         nxt_phase;

  always_comb begin
    nxt_ff    = cur_ff;
    tick_edge = cur_ff.tick_sync[1] & ~cur_ff.tick_sync[2];
    acc_sum   = {1'b0, cur_ff.acc} + STEPS_P;
    nxt_phase = cur_ff.phase;

    // Two flops before use; third only for edge detection
    nxt_ff.tick_sync = {cur_ff.tick_sync[1], cur_ff.tick_sync[0], i_sensor_tick};
    nxt_ff.rev_sync  = {cur_ff.rev_sync[0], i_sensor_rev};

    if (tick_edge) begin
      // Last period sets the step pitch of the next one
      nxt_ff.per_last = (cur_ff.per_cnt == PER_MAX) ? PER_MAX : cur_ff.per_cnt + 1'b1;
      nxt_ff.per_cnt  = '0;
      nxt_ff.acc      = '0;
      nxt_ff.steps    = '0;
      nxt_ff.valid    = 1'b1;
      nxt_ff.zero_cnt = ZERO_LEN;
    end else begin
      if (cur_ff.per_cnt == PER_MAX) begin
        // Flow stalled: stop stepping rather than spin on a stale pitch
        nxt_ff.valid = 1'b0;
      end else begin
        nxt_ff.per_cnt = cur_ff.per_cnt + 1'b1;
      end
      if (cur_ff.zero_cnt != 8'h00) begin
        nxt_ff.zero_cnt = cur_ff.zero_cnt - 1'b1;
      end
      // Rate accumulator: STEPS steps spread evenly over per_last cycles
      if (cur_ff.valid && cur_ff.steps < STEPS_W) begin
        if (acc_sum >= {1'b0, cur_ff.per_last}) begin
          nxt_ff.acc   = acc_sum[PERIOD_W-1:0] - cur_ff.per_last;
          nxt_ff.steps = cur_ff.steps + 1'b1;
          nxt_phase    = step_phase(cur_ff.phase, cur_ff.rev_sync[1]);
        end else begin
          nxt_ff.acc = acc_sum[PERIOD_W-1:0];
        end
      end
    end

    nxt_ff.phase = nxt_phase;
    // Decoded from the next phase so pins change in the same edge as the state
    nxt_ff.a = (nxt_phase == PH_10) || (nxt_phase == PH_11);
    nxt_ff.b = (nxt_phase == PH_11) || (nxt_phase == PH_01);
    nxt_ff.z = tick_edge || (cur_ff.zero_cnt > 8'h01);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_ff.tick_sync <= 3'h0;
      cur_ff.rev_sync  <= 2'h0;
      cur_ff.per_cnt   <= '0;
      cur_ff.per_last  <= '0;
      cur_ff.acc       <= '0;
      cur_ff.steps     <= '0;
      cur_ff.valid     <= 1'b0;
      cur_ff.phase     <= PH_00;
      cur_ff.zero_cnt  <= 8'h00;
      cur_ff.a         <= `QPO_IDLE_LEVEL;
      cur_ff.b         <= `QPO_IDLE_LEVEL;
      cur_ff.z         <= `QPO_IDLE_LEVEL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Pins straight from flops, glitch free
  assign link.chan_a     = cur_ff.a;
  assign link.chan_b     = cur_ff.b;
  assign link.zero_pulse = cur_ff.z;

  assign o_interp_factor = FACTOR[5:0];
  assign o_period_cycles = cur_ff.per_last;
  assign o_running       = cur_ff.valid;

endmodule

// *** verif/interpolated_quadrature_pulse_out_tb.sv ***
`timescale 1ns/1ps
module interpolated_quadrature_pulse_out_tb;
  import qpo_pkg::*;
  localparam int unsigned F = 2;
  logic          i_mclk  = 1'b0;
  logic          i_rst_n = 1'b0;
  logic          tick    = 1'b0;
  logic          rev     = 1'b0;
  eval_mode_type mode    = EVAL_QUAD;
  logic [31:0]   pos, vol, flow, zs;
  logic [23:0]   per;
  logic [5:0]    interp_factor;
  logic          run, dir, ovr;
  int            bad_count = 0;
  int            n_checks  = 0;
  int            cyc       = 0;

  quad_link_if link ();
  quad_pulse_dev #(.INTERP_FACTOR(F)) i_quad_pulse_dev (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_sensor_tick(tick), .i_sensor_rev(rev), .link(link), .o_interp_factor(interp_factor),
    .o_period_cycles(per), .o_running(run));
  quad_count_eval #(.FLOW_WIN_CYC(100)) i_quad_count_eval (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .link(link), .i_eval_mode(mode), .i_volume_per_count(32'h3), .i_clr_overrun(1'b0),
    .o_position(pos), .o_volume(vol), .o_flow(flow), .o_zero_seen(zs), .o_dir_rev(dir),
    .o_overrun(ovr));
  quad_link_assertions #(.INTERP_FACTOR(F)) i_quad_link_assertions (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .chan_a(link.chan_a), .chan_b(link.chan_b),
    .zero_pulse(link.zero_pulse));

  always #12.5 i_mclk = ~i_mclk;

  // Whole run is about 2240 cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_cyc(int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic do_reset();
    i_rst_n = 1'b0;
    wait_cyc(16);
    chk("idle", 32'h0, {link.chan_a, link.chan_b, link.zero_pulse, run, pos[0], zs[0]});
    i_rst_n = 1'b1;
  endtask

  // Gaps grow each period after a reset so the steps of one period end before the next tick
  task automatic pulse(int gap);
    tick = 1'b1;
    wait_cyc(4);
    tick = 1'b0;
    wait_cyc(gap - 4);
  endtask

  task automatic period(eval_mode_type m, int gap, logic [31:0] exp);
    logic [31:0] p0, v0, z0;
    mode = m;
    p0   = pos;
    v0   = vol;
    z0   = zs;
    pulse(gap);
    chk("position", exp, pos - p0);
    chk("volume", exp * 32'h3, vol - v0);
    chk("zero count", 32'h1, zs - z0);
  endtask

  task automatic t_forward();
    do_reset();
    pulse(300);
    period(EVAL_QUAD, 400, 32'(4 * F));
    period(EVAL_DOUBLE, 500, 32'(2 * F));
    chk("factor", 32'(F), 32'(interp_factor));
    chk("period", 32'd400, 32'(per));
    chk("running", 32'h1, 32'(run));
    chk("direction", 32'h0, 32'(dir));
  endtask

  task automatic t_reverse();
    pulse(60);
    do_reset();
    rev = 1'b1;
    pulse(300);
    period(EVAL_QUAD, 400, 32'h0 - 32'(4 * F));
    chk("direction", 32'h1, 32'(dir));
    chk("overrun", 32'h0, 32'(ovr));
    // Idle well past a full flow window, so the last window saw no counts
    wait_cyc(250);
    chk("flow", 32'h0, flow);
  endtask

  initial begin
    t_forward();
    t_reverse();
    complete_run();
  end
endmodule

// *** verif/quad_link_assertions.sv ***
`timescale 1ns/1ps
module quad_link_assertions #(
  parameter int unsigned INTERP_FACTOR = 8,
  parameter int unsigned ZERO_CYC      = 40
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic zero_pulse
);
  logic [7:0] zero_len_ff;
  logic [7:0] steps_ff;
  logic [1:0] last_ff;
  logic       armed_ff;
  logic       a_q_ff;
  logic       b_q_ff;
  logic       z_q_ff;
  logic       a_step;
  logic       b_step;

  // Edge history in registers, so release of reset sees no stale samples
  assign a_step = chan_a ^ a_q_ff;
  assign b_step = chan_b ^ b_q_ff;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {a_q_ff, b_q_ff, z_q_ff, armed_ff} <= 4'h0;
      {zero_len_ff, steps_ff, last_ff} <= 18'h0;
    end else begin
      a_q_ff      <= chan_a;
      b_q_ff      <= chan_b;
      z_q_ff      <= zero_pulse;
      zero_len_ff <= zero_pulse ? zero_len_ff + 8'h01 : 8'h00;
      if (zero_pulse) armed_ff <= 1'b1;
      if (zero_pulse && !z_q_ff) steps_ff <= 8'h00;
      else if (a_step || b_step) steps_ff <= steps_ff + 8'h01;
      if (a_step) last_ff <= 2'h1;
      else if (b_step) last_ff <= 2'h2;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_single_step: assert property (!(a_step && b_step))
    else $error("both channels moved at once");
  a_a_alternates: assert property (a_step |-> last_ff != 2'h1)
    else $error("channel a stepped twice in a row");
  a_b_alternates: assert property (b_step |-> last_ff != 2'h2)
    else $error("channel b stepped twice in a row");
  a_zero_hold: assert property ($rose(zero_pulse) |-> zero_pulse [*8])
    else $error("zero pulse too short");
  a_zero_length: assert property ($fell(zero_pulse) |-> zero_len_ff == ZERO_CYC)
    else $error("zero pulse length wrong");
  a_step_armed: assert property ((a_step || b_step) |-> armed_ff)
    else $error("step before first period");
  a_steps_bound: assert property ((zero_pulse && !z_q_ff) |-> steps_ff <= 4 * INTERP_FACTOR)
    else $error("too many steps in one period");
  a_idle_reset: assert property (disable iff (1'b0) !i_rst_n |-> !chan_a && !chan_b && !zero_pulse)
    else $error("link not idle in reset");
  a_idle_release: assert property (disable iff (1'b0)
    $rose(i_rst_n) |-> (!chan_a && !chan_b && !zero_pulse) [*3])
    else $error("link moved right after reset");
endmodule
